// *** common/lsa_params.svh ***
`ifndef LSA_PARAMS_SVH
`define LSA_PARAMS_SVH
// register byte offsets
`define LSA_ADDR_CTRL 12'h000
`define LSA_ADDR_CMD 12'h004
`define LSA_ADDR_STATUS 12'h008
`define LSA_ADDR_RXDATA 12'h00C
// control register fields
`define LSA_CTRL_MODE_LSB 0
`define LSA_CTRL_FREEZE_BIT 2
`define LSA_CTRL_SPHASE_LSB 4
`define LSA_CTRL_TXF_LSB 8
`define LSA_CTRL_RXF_LSB 12
`define LSA_CTRL_ROLL_LSB 16
`define LSA_CTRL_RST 32'h000A_AA00
// command and status fields
`define LSA_CMD_RECAL_BIT 0
`define LSA_STAT_LOCK_BIT 0
`define LSA_STAT_INIT_BIT 1
`define LSA_STAT_BUSY_BIT 2
`define LSA_STAT_PHASE_LSB 4
// timing
`define LSA_CLK_MHZ 100
`define LSA_CAL_TIME_NS 2000
`define LSA_LOCK_TIMEOUT_NS 400
`define LSA_CAL_CYCLES ((`LSA_CAL_TIME_NS * `LSA_CLK_MHZ) / 1000)
`define LSA_LOCK_TIMEOUT_CYCLES ((`LSA_LOCK_TIMEOUT_NS * `LSA_CLK_MHZ) / 1000)
`define LSA_LOCK_EDGES 15
`define LSA_INIT_LOCK_HITS 8
`endif

// *** common/lsa_pkg.sv ***
`default_nettype none
package lsa_pkg;
    // receiver alignment modes
    typedef enum logic [1:0] {
        LSA_MODE_STATIC = 2'h0,
        LSA_MODE_DYN = 2'h1,
        LSA_MODE_SCR = 2'h2
    } lsa_mode_t;
    // recalibration sequencer states, one-hot
    typedef enum logic [1:0] {
        LSA_CAL_IDLE = 2'b01,
        LSA_CAL_RUN = 2'b10
    } lsa_cal_state_t;
    // maps a programmed factor onto the legal set 4,6,7,8,10
    function automatic logic [3:0] lsa_factor_fix(input logic [3:0] f);
        case (f)
            4'h4, 4'h6, 4'h7, 4'h8, 4'hA: lsa_factor_fix = f;
            default: lsa_factor_fix = 4'hA;
        endcase
    endfunction : lsa_factor_fix
endpackage : lsa_pkg
`default_nettype wire

// *** core/lsa_tx_serializer.sv ***
`default_nettype none
module lsa_tx_serializer
    import lsa_pkg::*;
#(
    parameter int W = 10,
    parameter int DIV = 4
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [3:0] factor_in,
    input wire logic [W-1:0] data_in,
    output logic load_out,
    output logic serial_out,
    output logic serial_clk_out
);
    logic [7:0] div_q;
    logic [W-1:0] word_q;
    logic [3:0] idx_q;
    logic [3:0] fct;
    logic tick;
    assign fct = lsa_factor_fix(factor_in);
    assign tick = (div_q == 8'(DIV - 1));
    ////////////////////////////////////////////////////////////////
    // serial-rate clock divider
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            div_q <= 8'h00;
            serial_clk_out <= 1'b0;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            serial_clk_out <= (div_q < 8'(DIV / 2)); // high for DIV/2 cycles, starting one cycle into each bit
        end
    end
    ////////////////////////////////////////////////////////////////
    // load and shift registers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            word_q <= '0;
            idx_q <= 4'h0;
            serial_out <= 1'b0;
            load_out <= 1'b0;
        end else begin
            load_out <= 1'b0;
            if (tick) begin
                if (idx_q == 4'h0) begin
                    word_q <= data_in;
                    serial_out <= data_in[fct - 4'h1];
                    idx_q <= fct - 4'h1;
                    load_out <= 1'b1;
                end else begin
                    serial_out <= word_q[idx_q - 4'h1];
                    idx_q <= idx_q - 4'h1;
                end
            end
        end
    end
endmodule : lsa_tx_serializer
`default_nettype wire

// *** core/lsa_word_aligner.sv ***
`default_nettype none
module lsa_word_aligner
    import lsa_pkg::*;
#(
    parameter int W = 10
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic realign_rst_in,
    input wire logic bit_valid_in,
    input wire logic bit_in,
    input wire logic [3:0] factor_in,
    input wire logic [3:0] rollover_in,
    input wire logic slip_in,
    output logic [W-1:0] word_out,
    output logic word_valid_out,
    output logic rollover_out
);
    logic [W-1:0] sh_q;
    logic [3:0] cnt_q;
    logic [3:0] slips_q;
    logic pend_q;
    logic [3:0] fct;
    logic consume;
    logic [W-1:0] sh_d;
    assign fct = lsa_factor_fix(factor_in);
    assign consume = bit_valid_in & pend_q;
    assign sh_d = {sh_q[W-2:0], bit_in};
    ////////////////////////////////////////////////////////////////
    // pending slip; a new request beats the consume of the old one
    always_ff @(posedge clk_in or posedge realign_rst_in) begin
        if (realign_rst_in) begin
            pend_q <= 1'b0;
        end else if (srst_in) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= slip_in | (pend_q & ~consume);
        end
    end
    ////////////////////////////////////////////////////////////////
    // deserializer with bit-slip boundary shift
    always_ff @(posedge clk_in or posedge realign_rst_in) begin
        if (realign_rst_in) begin
            sh_q <= '0;
            cnt_q <= 4'h0;
            slips_q <= 4'h0;
            word_out <= '0;
            word_valid_out <= 1'b0;
            rollover_out <= 1'b0;
        end else if (srst_in) begin
            sh_q <= '0;
            cnt_q <= 4'h0;
            slips_q <= 4'h0;
            word_out <= '0;
            word_valid_out <= 1'b0;
            rollover_out <= 1'b0;
        end else begin
            word_valid_out <= 1'b0;
            rollover_out <= 1'b0;
            if (bit_valid_in) begin
                sh_q <= sh_d;
                if (consume) begin
                    // this bit is not counted: boundary moves one bit later
                    if (slips_q + 4'h1 >= rollover_in) begin
                        slips_q <= 4'h0;
                        rollover_out <= 1'b1;
                    end else begin
                        slips_q <= slips_q + 4'h1;
                    end
                end else if (cnt_q >= fct - 4'h1) begin
                    cnt_q <= 4'h0;
                    word_out <= sh_d & ((W'(1) << fct) - W'(1));
                    word_valid_out <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule : lsa_word_aligner
`default_nettype wire

// *** core/lsa_core.sv ***
// The APB interface to the registers and the register addresses were decided locally.
`include "lsa_params.svh"
`default_nettype none
module lsa_core
    import lsa_pkg::*;
#(
    parameter int W = 10,
    parameter int FIFO_DEPTH = 6,
    parameter int TX_DIV = 4,
    parameter int CAL_CYCLES = `LSA_CAL_CYCLES
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic link_clk_in,
    input wire logic rx_data_in,
    input wire logic slip_req_in,
    input wire logic aligner_rst_in,
    input wire logic fifo_rst_in,
    input wire logic realign_rst_in,
    input wire logic [W-1:0] tx_data_in,
    output logic tx_load_out,
    output logic tx_serial_out,
    output logic tx_serial_clk_out,
    output logic [W-1:0] rx_word_out,
    output logic rx_word_valid_out,
    output logic rx_par_clk_out,
    output logic rx_rec_clk_out,
    output logic slip_rollover_out,
    output logic pll_locked_out,
    output logic init_lock_out,
    output logic recal_busy_out
);
    logic [31:0] ctrl_q;
    logic [W-1:0] last_word_q;
    logic [2:0] sel_q;
    lsa_mode_t mode;
    logic freeze;
    logic [2:0] static_phase;
    logic [3:0] tx_factor;
    logic [3:0] rx_factor;
    logic [3:0] rollover;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic recal_req;
    assign mode = lsa_mode_t'(ctrl_q[`LSA_CTRL_MODE_LSB +: 2]);
    assign freeze = ctrl_q[`LSA_CTRL_FREEZE_BIT] & (mode != LSA_MODE_STATIC);
    assign static_phase = ctrl_q[`LSA_CTRL_SPHASE_LSB +: 3];
    assign tx_factor = ctrl_q[`LSA_CTRL_TXF_LSB +: 4];
    assign rx_factor = ctrl_q[`LSA_CTRL_RXF_LSB +: 4];
    assign rollover = ctrl_q[`LSA_CTRL_ROLL_LSB +: 4];
    ////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, error on unmapped address
    assign apb_wr = psel_in & penable_in & pwrite_in;
    assign apb_rd = psel_in & ~pwrite_in;
    assign addr_ok = (paddr_in == `LSA_ADDR_CTRL) || (paddr_in == `LSA_ADDR_CMD) ||
                     (paddr_in == `LSA_ADDR_STATUS) || (paddr_in == `LSA_ADDR_RXDATA);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_ok;
    assign recal_req = apb_wr & (paddr_in == `LSA_ADDR_CMD) & pwdata_in[`LSA_CMD_RECAL_BIT];
    // control register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_q <= `LSA_CTRL_RST;
        end else if (apb_wr && paddr_in == `LSA_ADDR_CTRL) begin
            ctrl_q <= pwdata_in & 32'h000F_FF77;
        end
    end
    // read data mux, registered during the setup phase
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (apb_rd) begin
            case (paddr_in)
                `LSA_ADDR_CTRL: prdata_out <= ctrl_q;
                `LSA_ADDR_STATUS: prdata_out <= {25'h000_0000, sel_q, 1'b0, recal_busy_out,
                                                 init_lock_out, pll_locked_out};
                `LSA_ADDR_RXDATA: prdata_out <= 32'(last_word_q);
                default: prdata_out <= 32'h0000_0000;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    // pin synchronizers for the link clock and serial data
    logic [1:0] lclk_sync_q;
    logic [1:0] rxd_sync_q;
    logic lclk_prev_q;
    logic rxd_prev_q;
    logic lclk_rise;
    logic rxd_edge;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lclk_sync_q <= 2'b00;
            rxd_sync_q <= 2'b00;
            lclk_prev_q <= 1'b0;
            rxd_prev_q <= 1'b0;
        end else begin
            lclk_sync_q <= {lclk_sync_q[0], link_clk_in};
            rxd_sync_q <= {rxd_sync_q[0], rx_data_in};
            lclk_prev_q <= lclk_sync_q[1];
            rxd_prev_q <= rxd_sync_q[1];
        end
    end
    assign lclk_rise = lclk_sync_q[1] & ~lclk_prev_q;
    assign rxd_edge = rxd_sync_q[1] ^ rxd_prev_q;
    ////////////////////////////////////////////////////////////////
    // pll lock: enough reference edges with no long gap
    logic [7:0] gap_q;
    logic [3:0] edges_q;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            gap_q <= 8'h00;
            edges_q <= 4'h0;
            pll_locked_out <= 1'b0;
        end else if (lclk_rise) begin
            gap_q <= 8'h00;
            if (edges_q != 4'(`LSA_LOCK_EDGES)) begin
                edges_q <= edges_q + 4'h1;
            end
            pll_locked_out <= (edges_q == 4'(`LSA_LOCK_EDGES));
        end else if (gap_q >= 8'(`LSA_LOCK_TIMEOUT_CYCLES)) begin
            edges_q <= 4'h0;
            pll_locked_out <= 1'b0;
        end else begin
            gap_q <= gap_q + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////
    // recalibration sequencer; touches neither lock nor phase state
    lsa_cal_state_t cal_q;
    logic [15:0] cal_cnt_q;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cal_q <= LSA_CAL_IDLE;
            cal_cnt_q <= 16'h0000;
        end else begin
            case (cal_q)
                LSA_CAL_IDLE: begin
                    if (recal_req) begin
                        cal_q <= LSA_CAL_RUN;
                        cal_cnt_q <= 16'(CAL_CYCLES - 1);
                    end
                end
                LSA_CAL_RUN: begin
                    if (cal_cnt_q == 16'h0000) begin
                        cal_q <= LSA_CAL_IDLE;
                    end else begin
                        cal_cnt_q <= cal_cnt_q - 16'h0001;
                    end
                end
                default: cal_q <= LSA_CAL_IDLE;
            endcase
        end
    end
    assign recal_busy_out = (cal_q == LSA_CAL_RUN);
    ////////////////////////////////////////////////////////////////
    // phase aligner: eight phases per reference period
    logic [2:0] ph_q;
    logic [2:0] tr_last_q;
    logic [3:0] hits_q;
    logic pa_bit_valid;
    always_ff @(posedge clk_in or posedge aligner_rst_in) begin
        if (aligner_rst_in) begin
            ph_q <= 3'h0;
            sel_q <= 3'h0;
            tr_last_q <= 3'h0;
            hits_q <= 4'h0;
            init_lock_out <= 1'b0;
        end else if (srst_in) begin
            ph_q <= 3'h0;
            sel_q <= 3'h0;
            tr_last_q <= 3'h0;
            hits_q <= 4'h0;
            init_lock_out <= 1'b0;
        end else begin
            ph_q <= lclk_rise ? 3'h0 : ph_q + 3'h1;
            if (mode == LSA_MODE_STATIC) begin
                sel_q <= static_phase;
            end else if (rxd_edge && !freeze) begin
                sel_q <= ph_q + 3'h4;
                tr_last_q <= ph_q;
                if (ph_q == tr_last_q && hits_q != 4'(`LSA_INIT_LOCK_HITS)) begin
                    hits_q <= hits_q + 4'h1;
                end
            end
            if (hits_q == 4'(`LSA_INIT_LOCK_HITS) && mode != LSA_MODE_STATIC) begin
                init_lock_out <= 1'b1;
            end
        end
    end
    assign pa_bit_valid = pll_locked_out & (ph_q == sel_q);
    ////////////////////////////////////////////////////////////////
    // synchronizer fifo between phase aligner and word aligner
    logic [FIFO_DEPTH-1:0] fifo_mem_q;
    logic [2:0] wr_ptr_q;
    logic [2:0] rd_ptr_q;
    logic [3:0] fill_q;
    logic fifo_clr;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_bit_q;
    logic fifo_valid_q;
    assign fifo_clr = aligner_rst_in | fifo_rst_in;
    assign fifo_pop = (fill_q != 4'h0);
    assign fifo_push = pa_bit_valid & (fill_q != 4'(FIFO_DEPTH) || fifo_pop);
    always_ff @(posedge clk_in or posedge fifo_clr) begin
        if (fifo_clr) begin
            fifo_mem_q <= '0;
            wr_ptr_q <= 3'h0;
            rd_ptr_q <= 3'h0;
            fill_q <= 4'h0;
            fifo_bit_q <= 1'b0;
            fifo_valid_q <= 1'b0;
        end else if (srst_in) begin
            fifo_mem_q <= '0;
            wr_ptr_q <= 3'h0;
            rd_ptr_q <= 3'h0;
            fill_q <= 4'h0;
            fifo_bit_q <= 1'b0;
            fifo_valid_q <= 1'b0;
        end else begin
            if (fifo_push) begin
                fifo_mem_q[wr_ptr_q] <= rxd_sync_q[1];
                wr_ptr_q <= (wr_ptr_q == 3'(FIFO_DEPTH - 1)) ? 3'h0 : wr_ptr_q + 3'h1;
            end
            if (fifo_pop) begin
                rd_ptr_q <= (rd_ptr_q == 3'(FIFO_DEPTH - 1)) ? 3'h0 : rd_ptr_q + 3'h1;
            end
            fill_q <= fill_q + {3'h0, fifo_push} - {3'h0, fifo_pop};
            fifo_bit_q <= fifo_mem_q[rd_ptr_q];
            fifo_valid_q <= fifo_pop;
        end
    end
    ////////////////////////////////////////////////////////////////
    // slip request edge detect; fabric holds it one cycle or more
    logic slip_prev_q;
    logic slip_rise;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            slip_prev_q <= 1'b0;
        end else begin
            slip_prev_q <= slip_req_in;
        end
    end
    assign slip_rise = slip_req_in & ~slip_prev_q;
    // word aligner
    lsa_word_aligner #(
        .W(W)
    ) u_align (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .realign_rst_in(realign_rst_in),
        .bit_valid_in(fifo_valid_q),
        .bit_in(fifo_bit_q),
        .factor_in(rx_factor),
        .rollover_in(rollover),
        .slip_in(slip_rise),
        .word_out(rx_word_out),
        .word_valid_out(rx_word_valid_out),
        .rollover_out(slip_rollover_out)
    );
    ////////////////////////////////////////////////////////////////
    // parallel clocks: rises with each word; one output per mode
    logic par_tog_q;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            par_tog_q <= 1'b0;
            rx_par_clk_out <= 1'b0;
            rx_rec_clk_out <= 1'b0;
            last_word_q <= '0;
        end else begin
            if (rx_word_valid_out) begin
                last_word_q <= rx_word_out;
            end
            par_tog_q <= rx_word_valid_out ? 1'b1 : (par_tog_q & ~lclk_rise);
            rx_par_clk_out <= par_tog_q & (mode != LSA_MODE_SCR);
            rx_rec_clk_out <= par_tog_q & (mode == LSA_MODE_SCR);
        end
    end
    ////////////////////////////////////////////////////////////////
    // transmitter
    lsa_tx_serializer #(
        .W(W),
        .DIV(TX_DIV)
    ) u_tx (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .factor_in(tx_factor),
        .data_in(tx_data_in),
        .load_out(tx_load_out),
        .serial_out(tx_serial_out),
        .serial_clk_out(tx_serial_clk_out)
    );
endmodule : lsa_core
`default_nettype wire

// *** verification/lsa_core_chk.sv ***
`default_nettype none
module lsa_core_chk #(
    parameter int CAL_CYCLES = 200
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic link_clk_in,
    input wire logic aligner_rst_in,
    input wire logic realign_rst_in,
    input wire logic tx_load_out,
    input wire logic tx_serial_out,
    input wire logic rx_word_valid_out,
    input wire logic rx_par_clk_out,
    input wire logic rx_rec_clk_out,
    input wire logic slip_rollover_out,
    input wire logic pll_locked_out,
    input wire logic init_lock_out,
    input wire logic recal_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] idle_q;
    logic [15:0] busy_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    ////////////////////////////////////////////////////////////////////////
    // cycles since the link clock pin last moved
    always_ff @(posedge clk_in) begin
        if (srst_in || $changed(link_clk_in)) begin
            idle_q <= 8'h00;
        end else if (idle_q != 8'hFF) begin
            idle_q <= idle_q + 8'h01;
        end
    end
    // length of the current busy stretch
    always_ff @(posedge clk_in) begin
        if (srst_in || !recal_busy_out) begin
            busy_q <= 16'h0000;
        end else begin
            busy_q <= busy_q + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    roll_pulse_a: assert property (slip_rollover_out |=> !slip_rollover_out)
        else $error("rollover longer than one cycle");
    realign_clr_a: assert property (realign_rst_in |-> !slip_rollover_out && !rx_word_valid_out)
        else $error("word aligner active in realign reset");
    init_sticky_a: assert property (disable iff (srst_in || aligner_rst_in) init_lock_out |=> init_lock_out)
        else $error("initial lock dropped");
    aligner_clr_a: assert property (aligner_rst_in |-> !init_lock_out)
        else $error("initial lock kept in aligner reset");
    busy_hold_a: assert property ($rose(recal_busy_out) |-> recal_busy_out [*8])
        else $error("busy too short");
    busy_len_a: assert property ($fell(recal_busy_out) |-> busy_q inside {[CAL_CYCLES - 1:CAL_CYCLES + 1]})
        else $error("calibration length wrong");
    load_gap_a: assert property (tx_load_out |=> !tx_load_out [*8])
        else $error("load strobes too close");
    ser_hold_a: assert property ($changed(tx_serial_out) |=> $stable(tx_serial_out) [*3])
        else $error("serial bit too short");
    clk_excl_a: assert property (!(rx_par_clk_out && rx_rec_clk_out))
        else $error("both parallel clocks active");
    lock_idle_a: assert property (idle_q > 8'h3C |-> !pll_locked_out)
        else $error("locked without link clock");
    reset_out_a: assert property ($fell(srst_in) |-> !pll_locked_out && !init_lock_out)
        else $error("lock flags set after reset");
endmodule : lsa_core_chk
bind lsa_core lsa_core_chk #(.CAL_CYCLES(CAL_CYCLES)) u_lsa_core_chk (.clk_in(clk_in), .srst_in(srst_in),
    .link_clk_in(link_clk_in), .aligner_rst_in(aligner_rst_in), .realign_rst_in(realign_rst_in),
    .tx_load_out(tx_load_out), .tx_serial_out(tx_serial_out), .rx_word_valid_out(rx_word_valid_out),
    .rx_par_clk_out(rx_par_clk_out), .rx_rec_clk_out(rx_rec_clk_out), .slip_rollover_out(slip_rollover_out),
    .pll_locked_out(pll_locked_out), .init_lock_out(init_lock_out), .recal_busy_out(recal_busy_out));
`default_nettype wire

// *** verification/lsa_link_partner.sv ***
`default_nettype none
module lsa_link_partner (
    input wire logic run_in,
    input wire logic [2:0] skew_in,
    input wire logic [3:0] factor_in,
    input wire logic [9:0] word_in,
    output logic link_clk_out,
    output logic data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx = 0;
    // eight 10 ns steps a link period; data moves at the chosen step
    initial begin
        link_clk_out = 1'b0;
        data_out = 1'b0;
        #3;
        forever begin
            for (int s = 0; s < 8; s++) begin
                link_clk_out = run_in && s < 4;
                if (!run_in) begin
                    data_out = ~data_out; // idle line keeps moving
                end else if (s == int'(skew_in)) begin
                    idx = (idx <= 0) ? int'(factor_in) - 1 : idx - 1;
                    data_out = word_in[idx];
                end
                #10;
            end
        end
    end
endmodule : lsa_link_partner
`default_nettype wire

// *** verification/tb.sv ***
`include "lsa_params.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, run = 1'b0;
    logic slip = 1'b0, arst = 1'b0, frst = 1'b0, rrst = 1'b0, e;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0000_0000, prd, r;
    logic prdy, perr, lclk, rxd, tld, tser, rxv, lock, ilock, busy, roll, pclk, rclk;
    logic [9:0] txd = 10'h2B5, rxw;
    logic [2:0] skew = 3'h2;
    int error_cnt = 0, checks = 0, rolls = 0, pcnt = 0, rcnt = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (roll === 1'b1) rolls++;
    // count parallel clock highs; the recovered clock counts any value that is not low
    always @(posedge clk) if (pclk === 1'b1) pcnt++;
    always @(posedge clk) if (rclk !== 1'b0) rcnt++;
    ////////////////////////////////////////////////////////////////////////
    lsa_core #(.CAL_CYCLES(10)) u_lsa_core (.clk_in(clk), .srst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .link_clk_in(lclk), .rx_data_in(rxd), .slip_req_in(slip), .aligner_rst_in(arst),
        .fifo_rst_in(frst), .realign_rst_in(rrst), .tx_data_in(txd), .tx_load_out(tld), .tx_serial_out(tser),
        .tx_serial_clk_out(), .rx_word_out(rxw), .rx_word_valid_out(rxv), .rx_par_clk_out(pclk),
        .rx_rec_clk_out(rclk), .slip_rollover_out(roll), .pll_locked_out(lock), .init_lock_out(ilock),
        .recal_busy_out(busy));
    lsa_link_partner u_lsa_link_partner (.run_in(run), .skew_in(skew), .factor_in(4'h4),
        .word_in(10'h008), .link_clk_out(lclk), .data_out(rxd));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic fail;
        error_cnt++;
        $display("[ERR] %0t wait timed out", $time);
        conclude;
    endtask : fail
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    // one apb transfer, entered right after an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= wr;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (prdy === 1'b1) break;
        end
        if (n == 20) fail;
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic ctrl(input logic frz, input logic [3:0] tf);
        apb(1'b1, `LSA_ADDR_CTRL, {12'h000, 4'h2, 4'h4, tf, 5'h00, frz, 2'h1});
    endtask : ctrl
    // sel: 0 load, 1 word, 2 lock, 3 idle calibration
    task automatic wait_for(input int sel, input int lim);
        int n;
        logic [3:0] v;
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            v = {busy === 1'b0, lock, rxv, tld};
            if (v[sel] === 1'b1) break;
        end
        if (n == lim) fail;
    endtask : wait_for
    task automatic pulse(input int sel);
        case (sel)
            0: slip <= 1'b1;
            1: arst <= 1'b1;
            2: frst <= 1'b1;
            default: rrst <= 1'b1;
        endcase
        step(2);
        {slip, arst, frst, rrst} <= 4'h0;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, `LSA_ADDR_CTRL, 32'h0000_0000);
        cmp(r, `LSA_CTRL_RST);
        apb(1'b0, 12'h010, 32'h0000_0000);
        cmp({r, e}, {32'h0000_0000, 1'b1});
    endtask : t_regs
    task automatic t_tx;
        logic [3:0] fl [5] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'hA};
        foreach (fl[i]) begin
            ctrl(1'b0, fl[i]);
            wait_for(0, 200);
            wait_for(0, 200);
            for (int b = int'(fl[i]) - 1; b >= 0; b--) begin
                cmp(tser, txd[b]);
                step(4);
            end
            cmp(tld, 1'b1);
        end
    endtask : t_tx
    task automatic t_rx;
        logic [9:0] w;
        run <= 1'b1;
        wait_for(2, 600);
        step(200);
        cmp(ilock, 1'b1);
        wait_for(1, 100);
        w = rxw;
        cmp($countones(w) == 1 && w < 10'h010, 1'b1);
        cmp({pcnt > 0, rcnt == 0}, 2'b11);
        for (int k = 1; k <= 4; k++) begin
            pulse(0);
            step(40);
            cmp(rolls, k / 2);
            wait_for(1, 100);
            wait_for(1, 100);
            w = {6'h00, w[2:0], w[3]};
            cmp(rxw, w);
        end
    endtask : t_rx
    task automatic t_rst;
        pulse(0);
        step(40);
        pulse(3);
        pulse(0);
        step(40);
        cmp(rolls, 2);
        pulse(0);
        step(40);
        cmp(rolls, 3);
        pulse(2);
        cmp({lock, ilock}, 2'b11);
        pulse(1);
        cmp({lock, ilock}, 2'b10);
        step(300);
    endtask : t_rst
    task automatic t_frz;
        logic [2:0] ph;
        apb(1'b0, `LSA_ADDR_STATUS, 32'h0000_0000);
        ph = r[6:4];
        ctrl(1'b1, 4'h4);
        skew <= 3'h6;
        step(300);
        apb(1'b0, `LSA_ADDR_STATUS, 32'h0000_0000);
        cmp(r[6:4], ph);
        ctrl(1'b0, 4'h4);
        step(300);
        apb(1'b0, `LSA_ADDR_STATUS, 32'h0000_0000);
        cmp(r[6:4] != ph, 1'b1);
    endtask : t_frz
    task automatic t_cal;
        apb(1'b1, `LSA_ADDR_CMD, 32'h0000_0001);
        apb(1'b0, `LSA_ADDR_STATUS, 32'h0000_0000);
        cmp(r[2], 1'b1);
        wait_for(3, 40);
        cmp({lock, ilock}, 2'b11);
        run <= 1'b0;
        step(80);
        cmp(lock, 1'b0);
    endtask : t_cal
    ////////////////////////////////////////////////////////////////////////
    initial begin
        step(12);
        rst <= 1'b0;
        step(1);
        t_regs;
        t_tx;
        t_rx;
        t_rst;
        t_frz;
        t_cal;
        conclude;
    end
endmodule : tb
`default_nettype wire
